// ---- design/lla_alu.sv ----
// Purpose: Xor, long add and long and datapath with an Avalon-MM window
// Assumes: Master holds each request until waitrequest is seen low
// Notes: Writing the instruction word with all four byte lanes executes it on the accepting edge
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module lla_alu #(
    parameter int unsigned DEBUG_LEVEL = 2,
    parameter int unsigned TRACE_SIZE = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Trace and status
    output logic trace_valid,
    output logic [13:0] trace_data,
    output logic carry_flag
);
    import lla_pkg::*;

    localparam bit TRACE_ON = (DEBUG_LEVEL == LLA_DEBUG_EXT) && (TRACE_SIZE > 0);

    lla_bus_t bus_state;
    lla_bus_t next_bus_state;
    logic acc_wr;
    logic exec;
    logic [31:0] last_instr;
    logic [47:0] prefix_val;
    logic imm32_pend;
    logic imml_pend;
    logic illegal;
    lla_gidx_t gpr_sel;
    lla_dec_t dec;
    lla_word_t src_a;
    lla_word_t src_b;
    lla_word_t rc_data;
    lla_word_t opb;
    lla_word_t long_imm;
    logic [31:0] xor_imm;
    logic [64:0] sum;
    logic cin_bit;
    logic wr_en;
    lla_gidx_t wr_idx;
    lla_word_t wr_data;
    logic [31:0] read_mux;

    // Byte-lane merge, shared by the prefix value and register-file data windows
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Instruction decode
    function automatic lla_dec_t decode(input logic [31:0] w);
        lla_dec_t d;
        logic [5:0] opc;
        logic long_sel;
        d.op = LLA_OP_NONE;
        d.rd = w[LLA_RD_LSB +: 5];
        d.ra = w[LLA_RA_LSB +: 5];
        d.rb = w[LLA_RB_LSB +: 5];
        d.imm = w[LLA_IMM_W-1:0];
        d.keep = w[LLA_K3];
        d.cin = w[LLA_C4];
        d.two_op = 1'b0;
        opc = w[LLA_OPC_LSB +: 6];
        long_sel = w[LLA_LONG_BIT];
        if (opc == LLA_OPC_XOR && w[10:0] == 11'h000) begin
            d.op = LLA_OP_XOR;
        end else if (opc == LLA_OPC_XORI) begin
            d.op = LLA_OP_XORI;
        end else if ((opc & LLA_OPC_ADD_MASK) == LLA_OPC_ADDL &&
                     w[10:0] == 11'h100) begin
            d.op = LLA_OP_ADDL;
        end else if ((opc & LLA_OPC_ADD_MASK) == LLA_OPC_ADDLI) begin
            d.op = LLA_OP_ADDLI;
        end else if (opc == LLA_OPC_TWO_OP &&
                     (d.ra & LLA_SUB_ADD_MASK) == 5'h00) begin
            // Two-operand add: selectors move into the rA field
            d.op = LLA_OP_ADDLI;
            d.two_op = 1'b1;
            d.keep = w[LLA_K13];
            d.cin = w[LLA_C14];
        end else if (opc == LLA_OPC_TWO_OP && d.ra == LLA_SUB_ANDLI) begin
            d.op = LLA_OP_ANDLI;
            d.two_op = 1'b1;
        end else if (opc == LLA_OPC_ANDL && long_sel && w[7:0] == 8'h00) begin
            d.op = LLA_OP_ANDL;
        end else if (opc == LLA_OPC_ANDLI) begin
            d.op = LLA_OP_ANDLI;
        end else if (opc == LLA_OPC_ANDNL && long_sel && w[7:0] == 8'h00) begin
            d.op = LLA_OP_ANDNL;
        end
        return d;
    endfunction

    // Bus handshake: one wait cycle, then answer
    always_comb begin
        case (bus_state)
            LLA_IDLE: next_bus_state = (avs_read || avs_write) ? LLA_ACK : LLA_IDLE;
            LLA_ACK: next_bus_state = LLA_IDLE;
            default: next_bus_state = LLA_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bus_state <= LLA_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest <= (next_bus_state != LLA_ACK);
        end
    end

    // Writes land only on the edge where waitrequest is low
    assign acc_wr = avs_write && (bus_state == LLA_ACK);
    assign exec = acc_wr && avs_address == LLA_ADDR_INSTR && avs_byteenable == 4'hf;
    assign dec = decode(avs_writedata);

    // Two-operand forms read the destination as first source
    lla_regfile u_regfile (
        .clk(clk),
        .ra_idx(dec.two_op ? dec.rd : dec.ra),
        .rb_idx(dec.rb),
        .rc_idx(gpr_sel),
        .ra_data(src_a),
        .rb_data(src_b),
        .rc_data(rc_data),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data)
    );

    // Immediate widening; prefix replaces the extension when armed
    assign xor_imm = imm32_pend ? {prefix_val[15:0], dec.imm}
                                : {{16{dec.imm[15]}}, dec.imm};
    assign long_imm = imml_pend ? {prefix_val, dec.imm}
                                : {{48{dec.imm[15]}}, dec.imm};

    // Full-width adder with carry-in
    assign opb = (dec.op == LLA_OP_ADDL) ? src_b : long_imm;
    assign cin_bit = dec.cin & carry_flag;
    assign sum = {1'b0, src_a} + {1'b0, opb} + {64'h0, cin_bit};

    // Result select and register-file write port
    always_comb begin
        wr_en = 1'b0;
        wr_idx = dec.rd;
        wr_data = 64'h0;
        if (exec) begin
            wr_en = (dec.op != LLA_OP_NONE);
            case (dec.op)
                LLA_OP_XOR: wr_data = {32'h0, src_a[31:0] ^ src_b[31:0]};
                LLA_OP_XORI: wr_data = {32'h0, src_a[31:0] ^ xor_imm};
                LLA_OP_ADDL: wr_data = sum[63:0];
                LLA_OP_ADDLI: wr_data = sum[63:0];
                LLA_OP_ANDL: wr_data = src_a & src_b;
                LLA_OP_ANDLI: wr_data = src_a & long_imm;
                LLA_OP_ANDNL: wr_data = src_a & ~src_b;
                default: wr_data = 64'h0;
            endcase
        end else if (acc_wr && avs_address == LLA_ADDR_GPR_LO) begin
            wr_en = 1'b1;
            wr_idx = gpr_sel;
            wr_data = {rc_data[63:32], merge(rc_data[31:0], avs_writedata, avs_byteenable)};
        end else if (acc_wr && avs_address == LLA_ADDR_GPR_HI) begin
            wr_en = 1'b1;
            wr_idx = gpr_sel;
            wr_data = {merge(rc_data[63:32], avs_writedata, avs_byteenable), rc_data[31:0]};
        end
    end

    // Carry flag: software write, or add without keep
    always_ff @(posedge clk) begin
        if (reset) begin
            carry_flag <= LLA_MSR_RST[LLA_MSR_CARRY];
        end else if (exec && (dec.op == LLA_OP_ADDL || dec.op == LLA_OP_ADDLI)) begin
            if (!dec.keep) begin
                carry_flag <= sum[64];
            end
        end else if (acc_wr && avs_address == LLA_ADDR_MSR && avs_byteenable[0]) begin
            carry_flag <= avs_writedata[LLA_MSR_CARRY];
        end
    end

    // Prefix value and arming; any executed word consumes the prefix
    always_ff @(posedge clk) begin
        if (reset) begin
            prefix_val <= 48'h0;
            imm32_pend <= 1'b0;
            imml_pend <= 1'b0;
        end else if (exec) begin
            imm32_pend <= 1'b0;
            imml_pend <= 1'b0;
        end else if (acc_wr) begin
            if (avs_address == LLA_ADDR_PFX_LO) begin
                prefix_val[31:0] <= merge(prefix_val[31:0], avs_writedata, avs_byteenable);
            end
            if (avs_address == LLA_ADDR_PFX_HI) begin
                prefix_val[47:32] <= 16'(merge({16'h0, prefix_val[47:32]}, avs_writedata,
                                               avs_byteenable));
            end
            if (avs_address == LLA_ADDR_PFX_CTRL && avs_byteenable[0]) begin
                imm32_pend <= avs_writedata[LLA_CTRL_IMM32];
                imml_pend <= avs_writedata[LLA_CTRL_IMML];
            end
        end
    end

    // Last word issued and operand selector for software
    always_ff @(posedge clk) begin
        if (reset) begin
            last_instr <= 32'h0;
            gpr_sel <= 5'h00;
        end else begin
            if (exec) begin
                last_instr <= avs_writedata;
            end
            if (acc_wr && avs_address == LLA_ADDR_GPR_SEL && avs_byteenable[0]) begin
                gpr_sel <= avs_writedata[4:0];
            end
        end
    end

    // Illegal word flag; a new set beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            illegal <= 1'b0;
        end else if (exec && dec.op == LLA_OP_NONE) begin
            illegal <= 1'b1;
        end else if (acc_wr && avs_address == LLA_ADDR_STATUS && avs_byteenable[0] &&
                     avs_writedata[LLA_ST_ILLEGAL]) begin
            illegal <= 1'b0;
        end
    end

    // Trace event from xori to the zero register
    always_ff @(posedge clk) begin
        if (reset) begin
            trace_valid <= 1'b0;
            trace_data <= 14'h0000;
        end else begin
            trace_valid <= TRACE_ON && exec && dec.op == LLA_OP_XORI &&
                           dec.rd == 5'h00;
            if (TRACE_ON && exec && dec.op == LLA_OP_XORI && dec.rd == 5'h00) begin
                trace_data <= wr_data[LLA_TRACE_W-1:0];
            end
        end
    end

    // Read data; unmapped offsets read zero
    always_comb begin
        case (avs_address)
            LLA_ADDR_INSTR: read_mux = last_instr;
            LLA_ADDR_PFX_LO: read_mux = prefix_val[31:0];
            LLA_ADDR_PFX_HI: read_mux = {16'h0, prefix_val[47:32]};
            LLA_ADDR_PFX_CTRL: read_mux = {30'h0, imml_pend, imm32_pend};
            LLA_ADDR_MSR: read_mux = {31'h0, carry_flag};
            LLA_ADDR_GPR_SEL: read_mux = {27'h0, gpr_sel};
            LLA_ADDR_GPR_LO: read_mux = rc_data[31:0];
            LLA_ADDR_GPR_HI: read_mux = rc_data[63:32];
            LLA_ADDR_STATUS: read_mux = {31'h0, illegal};
            default: read_mux = 32'h0;
        endcase
    end

    // Captured on the edge that drops waitrequest, held through the answer
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 32'h0;
        end else if (bus_state == LLA_IDLE && avs_read) begin
            avs_readdata <= read_mux;
        end
    end

    // Checks

    a_xor_result: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_XOR |-> wr_en && wr_idx == avs_writedata[25:21] &&
        wr_data[31:0] == (src_a[31:0] ^ src_b[31:0]))
        else $error("xor result wrong");

    a_xori_extend: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_XORI && !imm32_pend |->
        wr_data[31:16] == (src_a[31:16] ^ {16{avs_writedata[15]}}))
        else $error("xori extension wrong");

    a_xori_prefix: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_XORI && imm32_pend |->
        wr_data[31:16] == (src_a[31:16] ^ prefix_val[15:0]) ##1 !imm32_pend)
        else $error("xori prefix not used");

    a_trace_event: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_XORI && dec.rd == 5'h00 && TRACE_ON |=>
        trace_valid && trace_data == $past(wr_data[13:0]) ##1 !trace_valid)
        else $error("trace event missing");

    a_carry_in: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_ADDL |->
        wr_data == src_a + src_b + {63'h0, dec.cin & carry_flag})
        else $error("long add sum wrong");

    a_carry_keep: assert property (@(posedge clk) disable iff (reset)
        exec && (dec.op == LLA_OP_ADDL || dec.op == LLA_OP_ADDLI) && dec.keep |=>
        carry_flag == $past(carry_flag))
        else $error("carry changed under keep");

    a_carry_load: assert property (@(posedge clk) disable iff (reset)
        exec && (dec.op == LLA_OP_ADDL || dec.op == LLA_OP_ADDLI) && !dec.keep |=>
        carry_flag == $past(sum[64]))
        else $error("carry not loaded");

    a_imm_add: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_ADDLI |->
        wr_data == src_a + long_imm + {63'h0, dec.cin & carry_flag})
        else $error("long immediate add wrong");

    a_long_and: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_ANDL |-> wr_data == (src_a & src_b))
        else $error("long and wrong");

    a_imm_and: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_ANDLI |-> wr_data == (src_a & long_imm))
        else $error("long immediate and wrong");

    a_and_not: assert property (@(posedge clk) disable iff (reset)
        exec && dec.op == LLA_OP_ANDNL |-> wr_data == (src_a & ~src_b))
        else $error("long and-not wrong");

    a_one_cycle: assert property (@(posedge clk) disable iff (reset)
        avs_write && avs_address == LLA_ADDR_INSTR && bus_state == LLA_IDLE |=>
        !avs_waitrequest)
        else $error("instruction not taken in one cycle");

endmodule // lla_alu

// ---- design/lla_pkg.sv ----
// Purpose: Shared constants and types for the logic and long add datapath
// Assumes: 32-bit instruction word, bit 0 is the most significant bit
// Notes: Byte offsets of the software register window live here
//
// Operation
// - 32-bit xor: fields at bits 6, 11, 16; rD gets rA xor rB.
// - xori widens the 16-bit immediate to 32 bits (sign extension here).
// - After an imm prefix, xori uses the prefix as upper 16 bits.
// - xori to r0 emits a 14-bit trace event when tracing is configured.
// - Long ops use full 64 bits; addl writes rA plus rB.
// - addl bit 3 is keep-carry, bit 4 is carry-in.
// - addl carry-in set adds the carry flag, cleared ignores it.
// - addl keep-carry set leaves the carry flag unchanged.
// - addl keep-carry cleared loads carry out of bit 64.
// - addli adds extended immediate to rA, or rD in two-operand form.
// - addli keep at bit 3 or 13, carry-in at bit 4 or 14.
// - addli carry-in set adds the carry flag, else plain add.
// - addli keep set holds carry, cleared updates it from the add.
// - andl writes 64-bit rA and rB into rD.
// - andli ands rA or rD with the sign-extended, prefix-merged immediate.
// - andnl writes rA and not rB into rD.
package lla_pkg;

    // Register window, byte addresses
    localparam logic [5:0] LLA_ADDR_INSTR = 6'h00;
    localparam logic [5:0] LLA_ADDR_PFX_LO = 6'h04;
    localparam logic [5:0] LLA_ADDR_PFX_HI = 6'h08;
    localparam logic [5:0] LLA_ADDR_PFX_CTRL = 6'h0c;
    localparam logic [5:0] LLA_ADDR_MSR = 6'h10;
    localparam logic [5:0] LLA_ADDR_GPR_SEL = 6'h14;
    localparam logic [5:0] LLA_ADDR_GPR_LO = 6'h18;
    localparam logic [5:0] LLA_ADDR_GPR_HI = 6'h1c;
    localparam logic [5:0] LLA_ADDR_STATUS = 6'h20;

    // Bit positions inside software registers, and the MSR reset value
    localparam int LLA_CTRL_IMM32 = 0;
    localparam int LLA_CTRL_IMML = 1;
    localparam int LLA_MSR_CARRY = 0;
    localparam int LLA_ST_ILLEGAL = 0;
    localparam logic [31:0] LLA_MSR_RST = 32'h0000_0000;

    // Instruction field positions (LSB index of each field)
    localparam int LLA_OPC_LSB = 26;
    localparam int LLA_RD_LSB = 21;
    localparam int LLA_RA_LSB = 16;
    localparam int LLA_RB_LSB = 11;
    localparam int LLA_K3 = 28;
    localparam int LLA_C4 = 27;
    localparam int LLA_K13 = 18;
    localparam int LLA_C14 = 17;
    localparam int LLA_LONG_BIT = 8;

    // Opcodes and match masks
    localparam logic [5:0] LLA_OPC_XOR = 6'h22;
    localparam logic [5:0] LLA_OPC_XORI = 6'h2a;
    localparam logic [5:0] LLA_OPC_ADD_MASK = 6'h39;
    localparam logic [5:0] LLA_OPC_ADDL = 6'h00;
    localparam logic [5:0] LLA_OPC_ADDLI = 6'h08;
    localparam logic [5:0] LLA_OPC_TWO_OP = 6'h1a;
    localparam logic [5:0] LLA_OPC_ANDL = 6'h21;
    localparam logic [5:0] LLA_OPC_ANDLI = 6'h29;
    localparam logic [5:0] LLA_OPC_ANDNL = 6'h23;
    localparam logic [4:0] LLA_SUB_ANDLI = 5'h11;
    localparam logic [4:0] LLA_SUB_ADD_MASK = 5'h19;

    // Operand widths and extended debug level
    localparam int LLA_IMM_W = 16;
    localparam int LLA_IMML_W = 48;
    localparam int LLA_TRACE_W = 14;
    localparam int LLA_DEBUG_EXT = 2;

    typedef logic [4:0] lla_gidx_t;
    typedef logic [63:0] lla_word_t;

    // Decoded operation, one-hot
    typedef enum logic [7:0] {
        LLA_OP_NONE = 8'h01,
        LLA_OP_XOR = 8'h02,
        LLA_OP_XORI = 8'h04,
        LLA_OP_ADDL = 8'h08,
        LLA_OP_ADDLI = 8'h10,
        LLA_OP_ANDL = 8'h20,
        LLA_OP_ANDLI = 8'h40,
        LLA_OP_ANDNL = 8'h80
    } lla_op_t;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        LLA_IDLE = 2'b01,
        LLA_ACK = 2'b10
    } lla_bus_t;

    typedef struct packed {
        lla_op_t op;
        lla_gidx_t rd;
        lla_gidx_t ra;
        lla_gidx_t rb;
        logic [15:0] imm;
        logic keep;
        logic cin;
        logic two_op;
    } lla_dec_t;

endpackage

// ---- design/lla_regfile.sv ----
// Purpose: General register file, 32 long registers, three read ports
// Assumes: Register zero reads zero and ignores writes
// Notes: Reads are combinational so execution finishes in one cycle
`timescale 1ns/1ps
module lla_regfile (
    // Clock
    input wire logic clk,
    // Read ports
    input wire lla_pkg::lla_gidx_t ra_idx,
    input wire lla_pkg::lla_gidx_t rb_idx,
    input wire lla_pkg::lla_gidx_t rc_idx,
    output lla_pkg::lla_word_t ra_data,
    output lla_pkg::lla_word_t rb_data,
    output lla_pkg::lla_word_t rc_data,
    // Write port
    input wire logic wr_en,
    input wire lla_pkg::lla_gidx_t wr_idx,
    input wire lla_pkg::lla_word_t wr_data
);
    import lla_pkg::*;

    lla_word_t mem [0:31];

    // Zero register masks the array, so it never needs a reset
    function automatic lla_word_t rd_port(input lla_gidx_t idx);
        rd_port = (idx == 5'h00) ? 64'h0 : mem[idx];
    endfunction

    // Reads
    assign ra_data = rd_port(ra_idx);
    assign rb_data = rd_port(rb_idx);
    assign rc_data = rd_port(rc_idx);

    // Single write port
    always_ff @(posedge clk) begin
        if (wr_en && wr_idx != 5'h00) begin
            mem[wr_idx] <= wr_data;
        end
    end

endmodule // lla_regfile

// ---- tb/lla_alu_tb.sv ----
// Purpose: Self-checking bench for the xor, long add and long and datapath
// Assumes: The slave answers each bus request after one wait state
// Notes: Expected values come from a register file model kept in the bench
`timescale 1ns/1ps
module lla_alu_tb;
    import lla_pkg::*;
    typedef struct {string nm; logic [31:0] v;} lla_note_t;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, trace_valid, carry_flag;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed;
    logic [3:0] avs_byteenable;
    logic [13:0] trace_data;
    lla_note_t rd_q[$];
    lla_note_t note;
    logic [13:0] tr_q[$];
    lla_word_t rf[32];
    logic cy;
    int miscompares, compares;

    lla_alu #(.DEBUG_LEVEL(2), .TRACE_SIZE(1)) lla_alu_inst (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trace_valid(trace_valid),
        .trace_data(trace_data), .carry_flag(carry_flag));

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic cmp_read(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_trace(logic [13:0] e, logic [13:0] g);
        cmp_read("trace data", {18'h0, e}, {18'h0, g});
    endtask

    task automatic cmp_flag(logic e, logic g);
        cmp_read("carry port", {31'h0, e}, {31'h0, g});
    endtask

    task automatic tally_and_finish();
        if (rd_q.size() != 0 || tr_q.size() != 0) miscompares++;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One bus access; request held until waitrequest is sampled low
    task automatic bus(logic is_wr, logic [5:0] ad, logic [31:0] wd, logic [3:0] be, string nm);
        int n;
        n = 0;
        @(posedge clk);
        avs_write <= is_wr;
        avs_read <= !is_wr;
        avs_address <= ad;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            miscompares++;
            $display("FAIL waitrequest expected 0 seen 1");
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(logic [5:0] ad, logic [31:0] d);
        bus(1'b1, ad, d, 4'hf, "");
    endtask

    // Note goes in before the request, so the watcher finds it at the answer
    task automatic rd(logic [5:0] ad, logic [31:0] e, string nm);
        rd_q.push_back('{nm, e});
        bus(1'b0, ad, rnd(), 4'hf, nm);
    endtask

    task automatic set_gpr(int r, lla_word_t v);
        wr(LLA_ADDR_GPR_SEL, 32'(r));
        wr(LLA_ADDR_GPR_LO, v[31:0]);
        wr(LLA_ADDR_GPR_HI, v[63:32]);
        rf[r] = (r == 0) ? '0 : v;
    endtask

    task automatic chk_gpr(int r, string nm);
        wr(LLA_ADDR_GPR_SEL, 32'(r));
        rd(LLA_ADDR_GPR_LO, rf[r][31:0], nm);
        rd(LLA_ADDR_GPR_HI, rf[r][63:32], nm);
    endtask

    // One random instruction of kind sel, then result, carry and prefix checks
    task automatic run_op(int sel);
        int d, a, b;
        logic k, c, cn;
        logic [15:0] im;
        logic [31:0] pl, ph, ins;
        lla_word_t va, vb, r, ix;
        logic [64:0] s;
        d = (sel == 19) ? 0 : int'(rnd() % 31) + 1;
        a = (sel inside {[11:14], 17}) ? d : int'(rnd() % 31) + 1;
        b = (a == 31) ? 1 : a + 1;
        {k, c} = 2'(sel + 1);
        va = {rnd(), rnd()};
        vb = {rnd(), rnd()};
        im = 16'(rnd());
        pl = rnd();
        ph = rnd();
        cn = 1'(rnd());
        set_gpr(a, va);
        set_gpr(b, vb);
        wr(LLA_ADDR_MSR, {31'h0, cn});
        cy = cn;
        ix = {{48{im[15]}}, im};
        if (sel inside {[7:10], 16}) begin
            wr(LLA_ADDR_PFX_LO, pl);
            wr(LLA_ADDR_PFX_HI, {16'h0, ph[15:0]});
            wr(LLA_ADDR_PFX_CTRL, 32'h2);
            ix = {ph[15:0], pl, im};
        end
        case (sel)
            0: ins = {6'h22, 5'(d), 5'(a), 5'(b), 11'h0};
            1, 19: ins = {6'h2a, 5'(d), 5'(a), im};
            2: begin
                wr(LLA_ADDR_PFX_LO, pl);
                wr(LLA_ADDR_PFX_CTRL, 32'h1);
                ins = {6'h2a, 5'(d), 5'(a), im};
                ix[31:16] = pl[15:0];
            end
            3, 4, 5, 6: ins = {3'b000, k, c, 1'b0, 5'(d), 5'(a), 5'(b), 11'h100};
            7, 8, 9, 10: ins = {3'b001, k, c, 1'b0, 5'(d), 5'(a), im};
            11, 12, 13, 14: ins = {6'h1a, 5'(d), 2'b00, k, c, 1'b0, im};
            15: ins = {6'h21, 5'(d), 5'(a), 5'(b), 11'h100};
            16: ins = {6'h29, 5'(d), 5'(a), im};
            17: ins = {6'h1a, 5'(d), 5'h11, im};
            default: ins = {6'h23, 5'(d), 5'(a), 5'(b), 11'h100};
        endcase
        s = {1'b0, va} + {1'b0, (sel < 7) ? vb : ix} + 65'(c & cy);
        if (sel < 3 || sel == 19) r = {32'h0, va[31:0] ^ ix[31:0]};
        else if (sel < 15) r = s[63:0];
        else if (sel == 15) r = va & vb;
        else if (sel < 18) r = va & ix;
        else r = va & ~vb;
        if (sel == 0) r = {32'h0, va[31:0] ^ vb[31:0]};
        if (sel inside {[3:14]} && !k) cy = s[64];
        if (sel == 19) tr_q.push_back(r[13:0]);
        wr(LLA_ADDR_INSTR, ins);
        rf[d] = (d == 0) ? '0 : r;
        chk_gpr(d, "gpr result");
        rd(LLA_ADDR_MSR, {31'h0, cy}, "carry flag");
        rd(LLA_ADDR_PFX_CTRL, 32'h0, "prefix armed");
    endtask

    // Watcher: each answered read or trace pulse takes the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
            note = rd_q.pop_front();
            cmp_read(note.nm, note.v, avs_readdata);
            if (avs_address == LLA_ADDR_MSR) cmp_flag(note.v[0], carry_flag);
        end
        if (trace_valid === 1'b1) begin
            if (tr_q.size() > 0) cmp_trace(tr_q.pop_front(), trace_data);
            else begin
                miscompares++;
                $display("FAIL trace_valid expected 0 seen 1");
            end
        end
    end

    // Main sequence
    initial begin
        seed = 32'h0001_8626; // Start value 99878
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        miscompares = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(LLA_ADDR_MSR, 32'h0, "msr reset");
        rd(LLA_ADDR_STATUS, 32'h0, "status reset");
        rd(LLA_ADDR_PFX_CTRL, 32'h0, "prefix reset");
        rd(6'h3c, 32'h0, "unmapped");
        rf[0] = '0;
        chk_gpr(0, "r0 zero");
        for (int i = 0; i < 80; i++) run_op(i % 20);
        // Partial byte lanes must not execute the word
        set_gpr(5, 64'h1);
        set_gpr(6, 64'h3);
        set_gpr(7, 64'hff);
        bus(1'b1, LLA_ADDR_INSTR, {6'h22, 5'd7, 5'd5, 5'd6, 11'h0}, 4'h3, "");
        chk_gpr(7, "partial lanes");
        // Unknown word sets the sticky flag, write one clears it
        wr(LLA_ADDR_INSTR, 32'hfc00_0000);
        rd(LLA_ADDR_STATUS, 32'h1, "illegal set");
        rd(LLA_ADDR_INSTR, 32'hfc00_0000, "last word");
        wr(LLA_ADDR_STATUS, 32'h1);
        rd(LLA_ADDR_STATUS, 32'h0, "illegal clear");
        repeat (4) @(posedge clk);
        tally_and_finish();
    end

    // Watchdog, well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("FAIL watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule // lla_alu_tb
